/* core/deser_pins.sv */
// Error flag, FIFO load strobe and shared host/JTAG pin logic of the deserializer
`timescale 1ns/1ns

// Three-stage synchroniser; the filtered level moves once stages two and three agree
module pin_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] filt_q;
    logic [W-1:0] filt_d;

    // Take a new level only when the last two stages match
    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    // Synchroniser chain and filtered level
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q   <= RST;
            s2_q   <= RST;
            s3_q   <= RST;
            filt_q <= RST;
        end else begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    assign level = filt_q;

endmodule : pin_sync

module deser_pins (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    input  wire logic                                  sav_pulse,
    input  wire logic                                  frame_start,
    input  wire logic [deser_pins_pkg::ERR_W-1:0]      err_event,
    input  wire deser_pins_pkg::shared_pins_s          pins,
    input  wire logic                                  jtag_tdo,
    input  wire logic [deser_pins_pkg::WORD_W-1:0]     reg_rdata,
    output logic                                       fifo_load_strobe,
    output logic                                       data_error_n,
    output logic                                       serial_or_test_out_pin,
    output deser_pins_pkg::jtag_s                      jtag,
    output deser_pins_pkg::reg_req_s                   reg_req
);

    // Filtered pin levels
    deser_pins_pkg::shared_pins_s pins_lvl;

    // Pin synchronisers for all four shared pins
    pin_sync #(
        .W   (4),
        .RST (deser_pins_pkg::PINS_RST)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (pins),
        .level   (pins_lvl)
    );

    // ---------------- Mode and clock edge tracking ----------------
    logic mode_q;
    logic mode_d;
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic sclk_rise;
    logic sclk_fall;
    logic mode_change;

    // One mode level steers every shared pin at once
    always_comb begin
        mode_d      = pins_lvl.port_sel;
        sclk_prev_d = pins_lvl.sclk_tck;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_q      <= 1'b0;
            sclk_prev_q <= 1'b1;
        end else begin
            mode_q      <= mode_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    // Edges of the shared clock pin, found by sampling
    assign sclk_rise   = pins_lvl.sclk_tck & ~sclk_prev_q;
    assign sclk_fall   = ~pins_lvl.sclk_tck & sclk_prev_q;
    assign mode_change = mode_q ^ pins_lvl.port_sel;

    // ---------------- Host serial port ----------------
    deser_pins_pkg::host_state_e          hst_q;
    deser_pins_pkg::host_state_e          hst_d;
    logic [deser_pins_pkg::CNT_W-1:0]     cnt_q;
    logic [deser_pins_pkg::CNT_W-1:0]     cnt_d;
    logic [deser_pins_pkg::WORD_W-1:0]    sin_q;
    logic [deser_pins_pkg::WORD_W-1:0]    sin_d;
    logic [deser_pins_pkg::WORD_W-1:0]    sout_q;
    logic [deser_pins_pkg::WORD_W-1:0]    sout_d;
    logic [deser_pins_pkg::ADDR_W-1:0]    addr_q;
    logic [deser_pins_pkg::ADDR_W-1:0]    addr_d;
    logic                                 host_sel;
    logic [deser_pins_pkg::WORD_W-1:0]    sin_next;
    logic [deser_pins_pkg::WORD_W-1:0]    rd_word;
    logic [deser_pins_pkg::ADDR_W-1:0]    cmd_addr;
    logic                                 stat_read;
    logic                                 host_we;
    logic [deser_pins_pkg::ERR_W-1:0]     mask_q;
    logic [deser_pins_pkg::ERR_W-1:0]     status_q;

    // Chip select is active low and only counts in host mode
    assign host_sel = ~mode_q & ~pins_lvl.cs_tms & ~mode_change;
    assign sin_next = {sin_q[deser_pins_pkg::WORD_W-2:0], pins_lvl.serial_or_test_in_pin};
    assign cmd_addr = sin_next[deser_pins_pkg::CMD_ADDR_LSB +: deser_pins_pkg::ADDR_W];

    // Read data: own registers answered here, the rest from the register file
    always_comb begin
        rd_word = reg_rdata;
        if (cmd_addr == deser_pins_pkg::ADDR_ERR_STATUS) begin
            rd_word = {{(deser_pins_pkg::WORD_W-deser_pins_pkg::ERR_W){1'b0}}, status_q};
        end else if (cmd_addr == deser_pins_pkg::ADDR_ERR_MASK) begin
            rd_word = {{(deser_pins_pkg::WORD_W-deser_pins_pkg::ERR_W){1'b0}}, mask_q};
        end
    end

    // Sequencer: command word, then a write or read data word
    always_comb begin
        hst_d     = hst_q;
        cnt_d     = cnt_q;
        sin_d     = sin_q;
        sout_d    = sout_q;
        addr_d    = addr_q;
        stat_read = 1'b0;
        host_we   = 1'b0;
        if (!host_sel) begin
            hst_d = deser_pins_pkg::H_IDLE;
            cnt_d = '0;
        end else begin
            case (hst_q)
                deser_pins_pkg::H_IDLE: begin
                    hst_d = deser_pins_pkg::H_CMD;
                    cnt_d = '0;
                end
                deser_pins_pkg::H_CMD: begin
                    if (sclk_rise) begin
                        sin_d = sin_next;
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == deser_pins_pkg::CNT_CMD_LAST) begin
                            addr_d = cmd_addr;
                            if (sin_next[deser_pins_pkg::CMD_RW_POS]) begin
                                hst_d     = deser_pins_pkg::H_RD;
                                sout_d    = rd_word;
                                stat_read = (cmd_addr == deser_pins_pkg::ADDR_ERR_STATUS);
                            end else begin
                                hst_d = deser_pins_pkg::H_WR;
                            end
                        end
                    end
                end
                deser_pins_pkg::H_WR: begin
                    if (sclk_rise) begin
                        sin_d = sin_next;
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == deser_pins_pkg::CNT_DATA_LAST) begin
                            host_we = 1'b1;
                            hst_d   = deser_pins_pkg::H_CMD;
                        end
                    end
                end
                deser_pins_pkg::H_RD: begin
                    if (sclk_fall) begin
                        sout_d = {sout_q[deser_pins_pkg::WORD_W-2:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == deser_pins_pkg::CNT_DATA_LAST) begin
                            hst_d = deser_pins_pkg::H_CMD;
                        end
                    end
                end
                default: begin
                    hst_d = deser_pins_pkg::H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hst_q  <= deser_pins_pkg::H_IDLE;
            cnt_q  <= '0;
            sin_q  <= '0;
            sout_q <= '0;
            addr_q <= '0;
        end else begin
            hst_q  <= hst_d;
            cnt_q  <= cnt_d;
            sin_q  <= sin_d;
            sout_q <= sout_d;
            addr_q <= addr_d;
        end
    end

    // ---------------- Error mask and sticky status ----------------
    logic [deser_pins_pkg::ERR_W-1:0] mask_d;
    logic [deser_pins_pkg::ERR_W-1:0] status_d;
    logic                             err_n_q;
    logic                             err_n_d;

    // Mask high bits enable monitoring; host writes update it
    always_comb begin
        mask_d = mask_q;
        if (host_we && addr_q == deser_pins_pkg::ADDR_ERR_MASK) begin
            mask_d = sin_next[deser_pins_pkg::ERR_W-1:0];
        end
    end

    // Clear on frame start or status read; a new error in that cycle wins
    always_comb begin
        status_d = status_q;
        if (frame_start || stat_read) begin
            status_d = '0;
        end
        status_d = status_d | (err_event & mask_q);
        err_n_d  = ~(|status_d);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_q   <= deser_pins_pkg::ERR_MASK_RST;
            status_q <= deser_pins_pkg::ERR_STATUS_RST;
            err_n_q  <= 1'b1;
        end else begin
            mask_q   <= mask_d;
            status_q <= status_d;
            err_n_q  <= err_n_d;
        end
    end

    // ---------------- Output registers ----------------
    logic                     fifo_load_strobe_q;
    logic                     fifo_load_strobe_d;
    logic                     sout_pin_q;
    logic                     sout_pin_d;
    deser_pins_pkg::jtag_s    jtag_q;
    deser_pins_pkg::jtag_s    jtag_d;
    deser_pins_pkg::reg_req_s req_q;
    deser_pins_pkg::reg_req_s req_d;

    // Strobe low for the single clock carrying start of active video
    always_comb begin
        fifo_load_strobe_d = ~sav_pulse;
    end

    // Pin function multiplexer follows the registered mode
    always_comb begin
        jtag_d = '0;
        if (mode_q && !mode_change) begin
            jtag_d.tck_rise = sclk_rise;
            jtag_d.tck_fall = sclk_fall;
            jtag_d.tms      = pins_lvl.cs_tms;
            jtag_d.tdi      = pins_lvl.serial_or_test_in_pin;
            sout_pin_d      = jtag_tdo;
        end else if (hst_q == deser_pins_pkg::H_RD) begin
            sout_pin_d = sout_d[deser_pins_pkg::WORD_W-1];
        end else begin
            sout_pin_d = 1'b0;
        end
    end

    // Register file access: write after a full data word, read at command end
    always_comb begin
        req_d       = req_q;
        req_d.we    = host_we;
        req_d.re    = 1'b0;
        if (host_we) begin
            req_d.addr  = addr_q;
            req_d.wdata = sin_next;
        end else if (hst_q == deser_pins_pkg::H_CMD && hst_d == deser_pins_pkg::H_RD) begin
            req_d.re   = 1'b1;
            req_d.addr = cmd_addr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fifo_load_strobe_q  <= 1'b1;
            sout_pin_q <= 1'b0;
            jtag_q     <= '0;
            req_q      <= '0;
        end else begin
            fifo_load_strobe_q  <= fifo_load_strobe_d;
            sout_pin_q <= sout_pin_d;
            jtag_q     <= jtag_d;
            req_q      <= req_d;
        end
    end

    // Every output comes straight from a flip-flop
    assign fifo_load_strobe       = fifo_load_strobe_q;
    assign data_error_n           = err_n_q;
    assign serial_or_test_out_pin = sout_pin_q;
    assign jtag                   = jtag_q;
    assign reg_req                = req_q;

endmodule : deser_pins

/* core/deser_pins_pkg.sv */
// Constants, types and carriers for the error flag and shared host/test pin block
package deser_pins_pkg;

    // Widths of the error vector and of host serial words
    localparam int ERR_W  = 5;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 5;

    // Synchroniser depth for pins from outside the pixel clock domain
    localparam int SYNC_STAGES = 3;

    // Error condition bit positions in the status and mask registers
    localparam int ERR_CRC_POS  = 0;
    localparam int ERR_LINE_POS = 1;
    localparam int ERR_TRS_POS  = 2;
    localparam int ERR_EDH_POS  = 3;
    localparam int ERR_ANC_POS  = 4;

    // Internal register addresses served by this block
    localparam logic [ADDR_W-1:0] ADDR_ERR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ERR_MASK   = 8'h01;

    // Reset values
    localparam logic [ERR_W-1:0] ERR_MASK_RST   = 5'h1F;
    localparam logic [ERR_W-1:0] ERR_STATUS_RST = 5'h00;
    localparam logic [3:0]       PINS_RST       = 4'h6;

    // Command word layout: read flag on top, address in the low byte
    localparam int CMD_RW_POS   = 15;
    localparam int CMD_ADDR_LSB = 0;

    // Bit counter marks for a command word followed by a data word
    localparam logic [CNT_W-1:0] CNT_CMD_LAST  = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_DATA_LAST = 5'h1F;

    // Shared pins as seen at the package balls
    typedef struct packed {
        logic port_sel;
        logic cs_tms;
        logic sclk_tck;
        logic serial_or_test_in_pin;
    } shared_pins_s;

    // Strobes and levels handed to the boundary-scan logic
    typedef struct packed {
        logic tck_rise;
        logic tck_fall;
        logic tms;
        logic tdi;
    } jtag_s;

    // Access to the device's internal register file
    typedef struct packed {
        logic              we;
        logic              re;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } reg_req_s;

    // Host serial port sequencer states
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_CMD  = 4'b0010,
        H_WR   = 4'b0100,
        H_RD   = 4'b1000
    } host_state_e;

endpackage : deser_pins_pkg

/* test/deser_pins_asserts.sv */
// Concurrent checks on the ports of the error flag and shared pin block
`timescale 1ns/1ns
module deser_pins_asserts (
    input wire logic                              clk_sys,
    input wire logic                              rst_n,
    input wire logic                              sav_pulse,
    input wire logic                              frame_start,
    input wire logic [deser_pins_pkg::ERR_W-1:0]  err_event,
    input wire deser_pins_pkg::shared_pins_s      pins,
    input wire logic                              jtag_tdo,
    input wire logic [deser_pins_pkg::WORD_W-1:0] reg_rdata,
    input wire logic                              fifo_load_strobe,
    input wire logic                              data_error_n,
    input wire logic                              serial_or_test_out_pin,
    input wire deser_pins_pkg::jtag_s             jtag,
    input wire deser_pins_pkg::reg_req_s          reg_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Load strobe is low one cycle per start of video, high otherwise
    a_strobe_low: assert property (sav_pulse |=> !fifo_load_strobe)
        else $error("load strobe not low after start of video");
    a_strobe_rest: assert property (!sav_pulse |=> fifo_load_strobe)
        else $error("load strobe low without start of video");
    // Error flag is set only by events, holds, and clears at a frame
    a_flag_cause: assert property ($fell(data_error_n) |-> $past(err_event) != 5'h00)
        else $error("error flag fell without an error event");
    a_flag_hold: assert property (
        (pins.cs_tms [*5] ##0 (!data_error_n && !frame_start)) |=> !data_error_n)
        else $error("error flag released without frame or read");
    a_flag_frame: assert property (frame_start && err_event == 5'h00 |=> data_error_n)
        else $error("error flag not released at frame start");
    // Scan strobes stay quiet in host mode, test clock rise and register write strobes are single pulses, test data out follows
    a_host_quiet: assert property ((!pins.port_sel) [*6] |-> jtag == '0)
        else $error("scan outputs active in host mode");
    a_tck_pulse: assert property (jtag.tck_rise |=> (!jtag.tck_rise) [*3])
        else $error("test clock rise strobe too long");
    a_tdo_follow: assert property (
        (pins.port_sel [*7] ##0 $past(rst_n)) |-> serial_or_test_out_pin == $past(jtag_tdo))
        else $error("serial output does not follow test data out");
    a_write_pulse: assert property (reg_req.we |=> !reg_req.we && !reg_req.re)
        else $error("register write strobe too long");
endmodule : deser_pins_asserts

bind deser_pins deser_pins_asserts deser_pins_asserts_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .sav_pulse(sav_pulse), .frame_start(frame_start),
    .err_event(err_event), .pins(pins), .jtag_tdo(jtag_tdo), .reg_rdata(reg_rdata),
    .fifo_load_strobe(fifo_load_strobe), .data_error_n(data_error_n),
    .serial_or_test_out_pin(serial_or_test_out_pin), .jtag(jtag), .reg_req(reg_req)
);

/* test/host_model.sv */
// Host controller and boundary-scan tester model on the shared pins
`timescale 1ns/1ns
module host_model (
    output deser_pins_pkg::shared_pins_s pins,
    input  wire logic                    out_pin
);
    logic [15:0] rx_word;

    // Idle port: select, clock and serial input tied high, host mode
    initial begin
        pins = 4'h7;
        rx_word = 16'h0000;
    end

    // One 32-clock frame at 125 ns per link clock; mode high runs the scan port
    task automatic xfer(input logic mode, input logic [31:0] tx);
        pins.port_sel = mode;
        #250;
        pins.cs_tms = 1'b0;
        #125;
        for (int k = 31; k >= 0; k--) begin
            if (k < 16) begin
                rx_word = {rx_word[14:0], out_pin};
            end
            pins.sclk_tck = 1'b0;
            pins.serial_or_test_in_pin = tx[k];
            if (mode) begin
                pins.cs_tms = ~tx[k];
            end
            #63;
            pins.sclk_tck = 1'b1;
            #62;
        end
        #125;
        pins.cs_tms = 1'b1;
        pins.serial_or_test_in_pin = 1'b1;
        #125;
        pins.port_sel = 1'b0;
        #250;
    endtask : xfer
endmodule : host_model

/* test/testbench.sv */
// Self-checking bench for the error flag and shared host/test pin block
`timescale 1ns/1ns
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module testbench;
    logic                              clk_sys, rst_n, sav_pulse, frame_start, jtag_tdo;
    logic [deser_pins_pkg::ERR_W-1:0]  err_event;
    logic [deser_pins_pkg::WORD_W-1:0] reg_rdata;
    deser_pins_pkg::shared_pins_s      pins;
    logic                              fifo_load_strobe, data_error_n, out_pin;
    deser_pins_pkg::jtag_s             jtag;
    deser_pins_pkg::reg_req_s          reg_req;
    int                                fail_count, samples_checked, we_cnt, re_cnt, rise_cnt;
    int                                fall_cnt;
    logic [7:0]                        cap_addr;
    logic [15:0]                       cap_wdata;
    logic [31:0]                       tdi_bits, tms_bits;

    deser_pins deser_pins_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .sav_pulse(sav_pulse), .frame_start(frame_start),
        .err_event(err_event), .pins(pins), .jtag_tdo(jtag_tdo), .reg_rdata(reg_rdata),
        .fifo_load_strobe(fifo_load_strobe), .data_error_n(data_error_n),
        .serial_or_test_out_pin(out_pin), .jtag(jtag), .reg_req(reg_req)
    );
    host_model host_model_i (.pins(pins), .out_pin(out_pin));

    // 100 MHz pixel clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Tally register strobes and scan clock rises as they stand
    always @(posedge clk_sys) begin
        if (reg_req.we) begin
            we_cnt++;
            cap_addr = reg_req.addr;
            cap_wdata = reg_req.wdata;
        end
        if (reg_req.re) begin
            re_cnt++;
            cap_addr = reg_req.addr;
        end
        if (jtag.tck_fall) begin
            fall_cnt++;
        end
        if (jtag.tck_rise) begin
            rise_cnt++;
            tdi_bits = {tdi_bits[30:0], jtag.tdi};
            tms_bits = {tms_bits[30:0], jtag.tms};
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Back-to-back start of video on two clocks, then release
    task automatic t_strobe;
        sav_pulse = 1'b1;
        step(1);
        `CHECK(fifo_load_strobe, 1'b0)
        step(1);
        sav_pulse = 1'b0;
        `CHECK(fifo_load_strobe, 1'b0)
        step(1);
        `CHECK(fifo_load_strobe, 1'b1)
        $display("test strobe done");
    endtask : t_strobe

    // Every error kind sets the flag, which holds until frame start
    task automatic t_flag;
        for (int b = 0; b < deser_pins_pkg::ERR_W; b++) begin
            err_event = 5'h01 << b;
            step(1);
            err_event = 5'h00;
            `CHECK(data_error_n, 1'b0)
            step(4);
            `CHECK(data_error_n, 1'b0)
            frame_start = 1'b1;
            step(1);
            frame_start = 1'b0;
            `CHECK(data_error_n, 1'b1)
        end
        $display("test flag done");
    endtask : t_flag

    // Mask write, status read and clear, pass-through read and write
    task automatic t_host;
        host_model_i.xfer(1'b0, 32'h00010002);
        err_event = 5'h01;
        step(1);
        err_event = 5'h00;
        step(2);
        `CHECK(data_error_n, 1'b1)
        err_event = 5'h03;
        step(1);
        err_event = 5'h00;
        step(1);
        `CHECK(data_error_n, 1'b0)
        host_model_i.xfer(1'b0, 32'h80000000);
        `CHECK(host_model_i.rx_word, 16'h0002)
        `CHECK(data_error_n, 1'b1)
        host_model_i.xfer(1'b0, 32'h80000000);
        `CHECK(host_model_i.rx_word, 16'h0000)
        host_model_i.xfer(1'b0, 32'h80010000);
        `CHECK(host_model_i.rx_word, 16'h0002)
        host_model_i.xfer(1'b0, 32'h80400000);
        `CHECK(re_cnt, 4)
        `CHECK(cap_addr, 8'h40)
        `CHECK(host_model_i.rx_word, reg_rdata)
        host_model_i.xfer(1'b0, 32'h00221234);
        step(8);
        `CHECK(we_cnt, 2)
        `CHECK(cap_addr, 8'h22)
        `CHECK(cap_wdata, 16'h1234)
        `CHECK(rise_cnt, 0)
        $display("test host done");
    endtask : t_host

    // Scan mode: clock, select and data pins follow, test data out passes through
    task automatic t_jtag;
        fork
            host_model_i.xfer(1'b1, 32'hC3A50F96);
            for (int i = 0; i < 400; i++) begin
                step(1);
                if (i > 60) `CHECK(out_pin, jtag_tdo)
                jtag_tdo = i[0] ^ i[3];
            end
        join
        `CHECK(rise_cnt, 32)
        `CHECK(fall_cnt, 32)
        `CHECK(tdi_bits, 32'hC3A50F96)
        `CHECK(tms_bits, 32'h3C5AF069)
        $display("test jtag done");
    endtask : t_jtag

    // Reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        sav_pulse = 1'b0;
        frame_start = 1'b0;
        err_event = 5'h00;
        jtag_tdo = 1'b0;
        reg_rdata = 16'hA5C3;
        fail_count = 0;
        samples_checked = 0;
        we_cnt = 0;
        re_cnt = 0;
        rise_cnt = 0;
        fall_cnt = 0;
        step(16);
        rst_n = 1'b1;
        step(2);
        t_strobe();
        t_flag();
        t_host();
        t_jtag();
        close_out();
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        `CHECK(1'b0, 1'b1)
        close_out();
    end
endmodule : testbench
